// file: rtl/timer_irq_dma_regs.svh
// Register offsets, field positions and reset values of the timer
// interrupt/DMA control section.
// Assumes inclusion by the control module.
`ifndef TIMER_IRQ_DMA_REGS_SVH
`define TIMER_IRQ_DMA_REGS_SVH

`define ADDR_DMA_COUNTER_POINTER 8'hf0
`define ADDR_DMA_ADDRESS_POINTER 8'hf1
`define ADDR_TIMER_VECTOR_BASE 8'hf2
`define ADDR_IRQ_DMA_CONTROL 8'hf3
`define ADDR_LOOPBACK_CONNECTION 8'hf8
`define ADDR_IRQ_DMA_MASK 8'hff

`define RST_POINTER 8'h00
`define RST_VECTOR 8'h00
`define RST_IRQ_DMA_CONTROL 8'hc7
`define RST_LOOPBACK_CONNECTION 8'hfc
`define RST_IRQ_DMA_MASK 8'h00

`define LOOPBACK_UNUSED_BITS 6'h3f

`define MASK_GLOBAL 7
`define MASK_CAP0_DMA 6
`define MASK_CAP0_IRQ 5
`define MASK_CAP1_IRQ 4
`define MASK_CMP0_DMA 3
`define MASK_CMP0_IRQ 2
`define MASK_CMP1_IRQ 1
`define MASK_WRAP_IRQ 0

`define CTRL_CAP_DONE 7
`define CTRL_CMP_DONE 6
`define CTRL_CAP_SRC 5
`define CTRL_CMP_DST 4
`define CTRL_SWAP 3

`define PTR_SWAP_BIT 2
`define PTR_IDENT_BIT 1
`define PTR_SELECT_BIT 0

`define GROUP_WRAP 2'h0
`define GROUP_CAPTURE 2'h2
`define GROUP_COMPARE 2'h3

`endif

// file: rtl/timer_irq_dma_pkg.sv
// Types shared by the timer interrupt/DMA control section.
// Assumes the register header is available on the include path.
package timer_irq_dma_pkg;

    // Register bus request from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Timer events, one-cycle pulses
    typedef struct packed {
        logic capture0;
        logic capture1;
        logic compare0;
        logic compare1;
        logic wrap;
        logic capture0_eob;
        logic compare0_eob;
    } timer_events_t;

    // Interrupt request with its vector
    typedef struct packed {
        logic request;
        logic [7:0] vector;
        logic [2:0] priority_level;
    } irq_out_t;

    // DMA channel setup seen by the core DMA controller
    typedef struct packed {
        logic capture_request;
        logic compare_request;
        logic to_register_file;
        logic use_dma_segment;
        logic [5:0] counter_pointer_high;
        logic [5:0] address_pointer_high;
        logic capture_from_port;
        logic compare_to_port;
        logic [2:0] priority_level;
    } dma_cfg_t;

    // Complete register state
    typedef struct packed {
        logic [7:0] mask;
        logic [5:0] counter_pointer_high;
        logic counter_select;
        logic [5:0] address_pointer_high;
        logic memory_extension_select;
        logic [4:0] vector_high;
        logic capture_block_done;
        logic compare_block_done;
        logic capture_dma_source_select;
        logic compare_dma_dest_select;
        logic swap_enable;
        logic [2:0] priority_level;
        logic loopback_odd;
        logic loopback_even;
        logic channel_identity_bit;
        logic [7:0] rdata;
        irq_out_t irq;
        dma_cfg_t dma;
    } state_t;

endpackage : timer_irq_dma_pkg

// file: rtl/timer_irq_dma_control.sv
// Interrupt and DMA control section of a 16-bit multifunction timer.
// Assumes register accesses are single-cycle strobes from the core and
// that timer events arrive as one-cycle pulses on clk.
`timescale 1ns/1ps
`include "timer_irq_dma_regs.svh"

module timer_irq_dma_control
    import timer_irq_dma_pkg::*;
(
    input wire logic clk, // 20 MHz core clock
    input wire logic rst, // Synchronous reset, active high
    input wire reg_req_t req, // Register access strobe
    input wire timer_events_t events, // Timer and DMA event pulses
    input wire logic irq_ack, // Core accepted the pending request
    output logic [7:0] rdata, // Read data, valid cycle after read
    output irq_out_t irq, // Interrupt request and vector
    output dma_cfg_t dma, // DMA channel setup and requests
    output logic loopback_odd, // Route output A to input A, timers 1/3
    output logic loopback_even // Route output A to input A, timers 0/2
);

    state_t cur;
    state_t nxt;

    // **************************************************
    // Register read mux
    // **************************************************
    function automatic logic [7:0] read_reg(input state_t s,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `ADDR_IRQ_DMA_MASK: v = s.mask;
            `ADDR_DMA_COUNTER_POINTER: v = {s.counter_pointer_high,
                s.channel_identity_bit, s.counter_select};
            `ADDR_DMA_ADDRESS_POINTER: v = {s.address_pointer_high,
                s.channel_identity_bit, s.memory_extension_select};
            `ADDR_TIMER_VECTOR_BASE: v = {s.irq.vector[7:1], 1'b0};
            `ADDR_IRQ_DMA_CONTROL: v = {s.capture_block_done,
                s.compare_block_done, s.capture_dma_source_select,
                s.compare_dma_dest_select, s.swap_enable,
                s.priority_level};
            `ADDR_LOOPBACK_CONNECTION: v = {`LOOPBACK_UNUSED_BITS,
                s.loopback_odd, s.loopback_even};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    logic wr_mask;
    logic wr_cptr;
    logic wr_aptr;
    logic wr_vec;
    logic wr_ctrl;
    logic wr_loop;
    logic cap_eob;
    logic cmp_eob;
    logic cap_irq;
    logic cap1_irq;
    logic cmp_irq;
    logic cmp1_irq;
    logic wrap_irq;

    always_comb begin
        nxt = cur;
        wr_mask = req.wr && req.addr == `ADDR_IRQ_DMA_MASK;
        wr_cptr = req.wr && req.addr == `ADDR_DMA_COUNTER_POINTER;
        wr_aptr = req.wr && req.addr == `ADDR_DMA_ADDRESS_POINTER;
        wr_vec = req.wr && req.addr == `ADDR_TIMER_VECTOR_BASE;
        wr_ctrl = req.wr && req.addr == `ADDR_IRQ_DMA_CONTROL;
        wr_loop = req.wr && req.addr == `ADDR_LOOPBACK_CONNECTION;
        cap_eob = events.capture0_eob && cur.mask[`MASK_CAP0_DMA];
        cmp_eob = events.compare0_eob && cur.mask[`MASK_CMP0_DMA];

        // **************************************************
        // Software writes
        // **************************************************
        if (wr_mask) begin
            nxt.mask = req.wdata;
        end
        if (wr_cptr) begin
            nxt.counter_pointer_high = req.wdata[7:2];
            nxt.counter_select = req.wdata[`PTR_SELECT_BIT];
        end
        if (wr_aptr) begin
            nxt.address_pointer_high = req.wdata[7:2];
            nxt.memory_extension_select = req.wdata[`PTR_SELECT_BIT];
        end
        if (wr_vec) begin
            nxt.vector_high = req.wdata[7:3];
        end
        if (wr_ctrl) begin
            nxt.capture_dma_source_select = req.wdata[`CTRL_CAP_SRC];
            nxt.compare_dma_dest_select = req.wdata[`CTRL_CMP_DST];
            nxt.swap_enable = req.wdata[`CTRL_SWAP];
            nxt.priority_level = req.wdata[2:0];
            // Done flags are cleared by writing zero with the swap bit set
            if (!req.wdata[`CTRL_CAP_DONE]) begin
                nxt.capture_block_done = 1'b0;
            end
            if (!req.wdata[`CTRL_CMP_DONE]) begin
                nxt.compare_block_done = 1'b0;
            end
        end
        if (wr_loop) begin
            nxt.loopback_odd = req.wdata[1];
            nxt.loopback_even = req.wdata[0];
        end

        // **************************************************
        // End of block handling, hardware wins over software
        // **************************************************
        // Disarm capture and compare DMA
        if (cap_eob) begin
            nxt.mask[`MASK_CAP0_DMA] = 1'b0;
        end
        if (cmp_eob) begin
            nxt.mask[`MASK_CMP0_DMA] = 1'b0;
        end
        if (cur.swap_enable) begin
            if (cap_eob) begin
                nxt.capture_block_done = 1'b1;
            end
            if (cmp_eob) begin
                nxt.compare_block_done = 1'b1;
            end
            // Alternate table on each end of block, unless both channels end in the same cycle
            if (cap_eob ^ cmp_eob) begin
                nxt.counter_pointer_high[0] = ~nxt.counter_pointer_high[0];
                nxt.address_pointer_high[0] = ~nxt.address_pointer_high[0];
            end
        end
        if (!nxt.swap_enable) begin
            nxt.capture_block_done = 1'b1;
            nxt.compare_block_done = 1'b1;
        end

        if (events.capture0 && cur.mask[`MASK_CAP0_DMA]) begin
            nxt.channel_identity_bit = 1'b0;
        end else if (events.compare0 && cur.mask[`MASK_CMP0_DMA]) begin
            nxt.channel_identity_bit = 1'b1;
        end

        // **************************************************
        // Interrupt requests
        // **************************************************
        // Capture-0 and compare-0 source choice
        cap_irq = cur.mask[`MASK_CAP0_IRQ] &&
                  (cur.mask[`MASK_CAP0_DMA] ? cap_eob : events.capture0);
        cmp_irq = cur.mask[`MASK_CMP0_IRQ] &&
                  (cur.mask[`MASK_CMP0_DMA] ? cmp_eob : events.compare0);
        cap1_irq = cur.mask[`MASK_CAP1_IRQ] && events.capture1;
        cmp1_irq = cur.mask[`MASK_CMP1_IRQ] && events.compare1;
        wrap_irq = cur.mask[`MASK_WRAP_IRQ] && events.wrap;

        if (irq_ack) begin
            nxt.irq.request = 1'b0;
        end
        if (cur.mask[`MASK_GLOBAL] && !cur.irq.request) begin
            if (cmp_irq || cmp1_irq) begin
                nxt.irq.request = 1'b1;
                nxt.irq.vector[2:1] = `GROUP_COMPARE;
            end else if (cap_irq || cap1_irq) begin
                nxt.irq.request = 1'b1;
                nxt.irq.vector[2:1] = `GROUP_CAPTURE;
            end else if (wrap_irq) begin
                nxt.irq.request = 1'b1;
                nxt.irq.vector[2:1] = `GROUP_WRAP;
            end
        end
        if (!nxt.mask[`MASK_GLOBAL]) begin
            nxt.irq.request = 1'b0;
        end
        nxt.irq.vector[7:3] = nxt.vector_high;
        nxt.irq.vector[0] = 1'b0;
        nxt.irq.priority_level = nxt.priority_level;

        // **************************************************
        // DMA setup outputs
        // **************************************************
        nxt.dma.capture_request = events.capture0 &&
                                  cur.mask[`MASK_CAP0_DMA];
        nxt.dma.compare_request = events.compare0 &&
                                  cur.mask[`MASK_CMP0_DMA];
        nxt.dma.to_register_file = nxt.counter_select;
        // Segment register choice only for memory
        nxt.dma.use_dma_segment = !nxt.counter_select &&
                                  nxt.memory_extension_select;
        nxt.dma.counter_pointer_high = nxt.counter_pointer_high;
        // Address pointer zeroed for register file, except bit 0 when swap is enabled
        nxt.dma.address_pointer_high = nxt.counter_select ?
            {5'h00, nxt.swap_enable & nxt.address_pointer_high[0]} :
            nxt.address_pointer_high;
        nxt.dma.capture_from_port = nxt.capture_dma_source_select;
        nxt.dma.compare_to_port = nxt.compare_dma_dest_select;
        nxt.dma.priority_level = nxt.priority_level;

        nxt.rdata = req.rd ? read_reg(cur, req.addr) : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.mask <= `RST_IRQ_DMA_MASK;
            cur.capture_block_done <= 1'b1;
            cur.compare_block_done <= 1'b1;
            cur.priority_level <= 3'h7;
            cur.loopback_odd <= 1'b0;
            cur.loopback_even <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    assign rdata = cur.rdata;
    assign irq = cur.irq;
    assign dma = cur.dma;
    assign loopback_odd = cur.loopback_odd;
    assign loopback_even = cur.loopback_even;

endmodule : timer_irq_dma_control

// file: tb/timer_irq_dma_properties.sv
// Port checker for the timer interrupt/DMA control section.
// Assumes it is bound to the top module by the bench.
`timescale 1ns/1ps
module timer_irq_dma_properties
    import timer_irq_dma_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire reg_req_t req, // Register access
    input wire timer_events_t events, // Event pulses
    input wire logic irq_ack, // Acknowledge
    input wire logic [7:0] rdata, // Read data
    input wire irq_out_t irq, // Interrupt
    input wire dma_cfg_t dma, // DMA setup
    input wire logic loopback_odd, // Loopback odd
    input wire logic loopback_even // Loopback even
);
    logic [7:0] mk;
    logic [4:0] base;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow of mask and vector base
    always_ff @(posedge clk) begin
        if (rst) begin
            mk <= 8'h00;
            base <= 5'h00;
        end else begin
            if (req.wr && req.addr == 8'hff) mk <= req.wdata;
            if (req.wr && req.addr == 8'hf2) base <= req.wdata[7:3];
            if (events.capture0_eob) mk[6] <= 1'b0;
            if (events.compare0_eob) mk[3] <= 1'b0;
        end
    end
    a_global_gate: assert property (!mk[7] && !$past(mk[7]) |->
        !irq.request) else $error("request with global enable low");
    a_vector_fixed: assert property (irq.request |->
        !irq.vector[0] && irq.vector[2:1] != 2'h1) else $error("bad vector");
    a_vector_base: assert property ($rose(irq.request) |->
        irq.vector[7:3] == $past(base)) else $error("bad vector base");
    a_cap1_raise: assert property (events.capture1 && mk[4] && mk[7] &&
        !irq.request && !irq_ack |=> irq.request) else $error("no request");
    a_cap1_block: assert property (events == 7'h20 && !mk[4] &&
        !irq.request |=> !irq.request) else $error("masked request");
    a_wrap_group: assert property ($rose(irq.request) &&
        $past(events == 7'h04 && mk[0]) |-> irq.vector[2:1] == 2'h0)
        else $error("bad wrap group");
    a_cmp1_group: assert property ($rose(irq.request) &&
        $past(events.compare1 && mk[1]) |-> irq.vector[2:1] == 2'h3)
        else $error("bad compare group");
    a_cap_dma: assert property (1'b1 |=> dma.capture_request ==
        $past(events.capture0 && mk[6])) else $error("capture dma request");
    a_cmp_dma: assert property (1'b1 |=> dma.compare_request ==
        $past(events.compare0 && mk[3])) else $error("compare dma request");
    a_cap0_quiet: assert property (events == 7'h40 && mk[6] &&
        !irq.request |=> !irq.request) else $error("irq while dma armed");
    a_level_tie: assert property (
        dma.priority_level == irq.priority_level) else $error("level split");
    c_irq: cover property ($rose(irq.request));
    c_cap: cover property (dma.capture_request);
    c_cmp: cover property (dma.compare_request);
endmodule : timer_irq_dma_properties

// file: tb/core_service_model.sv
// Core interrupt and DMA controller model facing the block.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module core_service_model
    import timer_irq_dma_pkg::*;
#(
    parameter int BLOCK = 2 // Transfers in one block
)
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic slow, // Late acknowledge
    input wire irq_out_t irq, // Request
    input wire dma_cfg_t dma, // DMA requests
    output logic irq_ack, // Acknowledge pulse
    output logic cap_eob, // Capture block end
    output logic cmp_eob // Compare block end
);
    int wait_n;
    int cap_n;
    int cmp_n;
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ack <= 1'b0;
            wait_n <= 0;
            cap_n <= 0;
            cmp_n <= 0;
            cap_eob <= 1'b0;
            cmp_eob <= 1'b0;
        end else begin
            irq_ack <= irq.request && !irq_ack && wait_n >= (slow ? 3 : 0);
            wait_n <= (irq.request && !irq_ack) ? wait_n + 1 : 0;
            cap_eob <= dma.capture_request && cap_n == BLOCK - 1;
            cmp_eob <= dma.compare_request && cmp_n == BLOCK - 1;
            if (dma.capture_request) cap_n <= (cap_n + 1) % BLOCK;
            if (dma.compare_request) cmp_n <= (cmp_n + 1) % BLOCK;
        end
    end
endmodule : core_service_model

// file: tb/testbench.sv
// Self-checking bench for the timer interrupt/DMA control section.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
    import timer_irq_dma_pkg::*;
    typedef struct {
        logic [7:0] mask;
        logic [4:0] ev;
        logic req;
        logic [1:0] grp;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic [4:0] pulse = 5'h00;
    reg_req_t req = '0;
    timer_events_t events;
    logic irq_ack, cap_eob, cmp_eob, lo, le;
    logic [7:0] rdata;
    irq_out_t irq;
    dma_cfg_t dma;
    int failures = 0;
    int compares = 0;
    row_t rows[8] = '{'{8'h90, 5'h08, 1, 2}, '{8'h82, 5'h02, 1, 3},
        '{8'h81, 5'h01, 1, 0}, '{8'ha0, 5'h10, 1, 2},
        '{8'h84, 5'h04, 1, 3}, '{8'h93, 5'h0b, 1, 3},
        '{8'h7f, 5'h0b, 0, 0}, '{8'h80, 5'h1f, 0, 0}};
    always #25 clk = ~clk;
    assign events = {pulse, cap_eob, cmp_eob};
    timer_irq_dma_control dut (.clk(clk), .rst(rst), .req(req),
        .events(events), .irq_ack(irq_ack), .rdata(rdata), .irq(irq),
        .dma(dma), .loopback_odd(lo), .loopback_even(le));
    core_service_model #(.BLOCK(2)) peer (.clk(clk), .rst(rst),
        .slow(slow), .irq(irq), .dma(dma), .irq_ack(irq_ack),
        .cap_eob(cap_eob), .cmp_eob(cmp_eob));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
    endtask : access
    task automatic rd_chk(input logic [7:0] a, exp, m);
        access(1'b0, a, 8'h00);
        check(rdata & m, exp);
    endtask : rd_chk
    task automatic fire(input logic [4:0] p);
        @(posedge clk);
        pulse <= p;
        @(posedge clk);
        pulse <= 5'h00;
    endtask : fire
    task automatic wait_irq(input logic [1:0] grp);
        int n;
        n = 0;
        while (irq.request !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        check(irq.request, 1'b1);
        check(irq.vector, {5'h15, grp, 1'b0});
        n = 0;
        while (irq.request !== 1'b0 && n < 12) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_irq
    task automatic end_test(input string name);
        $display("test %s done, failures %0d", name, failures);
    endtask : end_test
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #(3000 * 50);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'hff, 8'h00, 8'hff);
        rd_chk(8'hf3, 8'hc7, 8'hff);
        rd_chk(8'hf8, 8'hfc, 8'hff);
        rd_chk(8'hf4, 8'h00, 8'hff);
        check(irq.priority_level, 3'h7);
        end_test("reset");
        access(1'b1, 8'hf2, 8'ha9);
        rd_chk(8'hf2, 8'ha8, 8'hf9);
        access(1'b1, 8'hf8, 8'h02);
        rd_chk(8'hf8, 8'hfe, 8'hff);
        check({lo, le}, 2'b10);
        access(1'b1, 8'hf3, 8'h35);
        rd_chk(8'hf3, 8'hf5, 8'hff);
        check({dma.capture_from_port, dma.compare_to_port,
            irq.priority_level, dma.priority_level}, 8'hed);
        access(1'b1, 8'hf0, 8'h54);
        access(1'b1, 8'hf1, 8'ha9);
        rd_chk(8'hf0, 8'h54, 8'hff);
        rd_chk(8'hf1, 8'ha9, 8'hff);
        check({dma.to_register_file, dma.use_dma_segment,
            dma.counter_pointer_high, dma.address_pointer_high}, 16'h156a);
        end_test("config");
        foreach (rows[i]) begin
            access(1'b1, 8'hff, rows[i].mask);
            fire(rows[i].ev);
            if (rows[i].req) begin
                wait_irq(rows[i].grp);
            end else begin
                repeat (4) @(negedge clk);
                check(irq.request, 1'b0);
            end
        end
        end_test("table");
        slow <= 1'b1;
        access(1'b1, 8'hf3, 8'h0d);
        access(1'b1, 8'hf3, 8'h0d);
        rd_chk(8'hf3, 8'h0d, 8'hff);
        access(1'b1, 8'hff, 8'he0);
        fire(5'h10);
        repeat (3) @(negedge clk);
        check(irq.request, 1'b0);
        fire(5'h10);
        wait_irq(2'h2);
        rd_chk(8'hff, 8'ha0, 8'hff);
        rd_chk(8'hf3, 8'h8d, 8'hff);
        rd_chk(8'hf0, 8'h50, 8'hff);
        rd_chk(8'hf1, 8'had, 8'hff);
        access(1'b1, 8'hff, 8'h8c);
        fire(5'h04);
        fire(5'h04);
        wait_irq(2'h3);
        rd_chk(8'hff, 8'h84, 8'hff);
        rd_chk(8'hf3, 8'hcd, 8'hff);
        rd_chk(8'hf0, 8'h56, 8'hff);
        rd_chk(8'hf1, 8'hab, 8'hff);
        access(1'b1, 8'hf1, 8'had);
        access(1'b1, 8'hf0, 8'h55);
        check({dma.to_register_file, dma.use_dma_segment,
            dma.address_pointer_high}, 8'h81);
        access(1'b1, 8'hf3, 8'h05);
        rd_chk(8'hf3, 8'hc5, 8'hff);
        end_test("swap");
        wrap_up();
    end
endmodule : testbench
bind timer_irq_dma_control timer_irq_dma_properties chk (.clk(clk),
    .rst(rst), .req(req), .events(events), .irq_ack(irq_ack),
    .rdata(rdata), .irq(irq), .dma(dma), .loopback_odd(loopback_odd),
    .loopback_even(loopback_even));
